/* File: dv/downstream_power_protection_props.sv */
// checker: port-level timing relations of the protection block
`timescale 1ns/1ps
module downstream_power_protection_props
(
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] transmit_enable_pin,
  input wire logic [1:0] sync_rotation,
  input wire logic [1:0] blank_settled,
  input wire logic [1:0] blanking_start,
  input wire logic [1:0] pair_powerdown,
  input wire logic [1:0] output_valid,
  input wire logic [1:0] power_alarm_event
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // -------------------------------------------------------------------
  // properties
  // -------------------------------------------------------------------
  property p_rdata_holds;
    !$past(reg_rd) |-> $stable(reg_rdata);
  endproperty
  property p_rotation_blanks;
    $rose(sync_rotation[1]) |-> ##[1:2] blanking_start[1];
  endproperty
  property p_blank_pulse;
    blanking_start[0] && !sync_rotation[0] && !$past(sync_rotation[0]) |=> !blanking_start[0];
  endproperty
  // pin goes through two sync flops, so the fall is seen a few edges late
  property p_pd_a;
    $rose(pair_powerdown[0]) |-> !$past(transmit_enable_pin[0], 2)
      || !$past(transmit_enable_pin[0], 3) || !$past(transmit_enable_pin[0], 4);
  endproperty
  property p_pd_b;
    $rose(pair_powerdown[1]) |-> !$past(transmit_enable_pin[1], 2)
      || !$past(transmit_enable_pin[1], 3) || !$past(transmit_enable_pin[1], 4);
  endproperty
  property p_valid_settled;
    $rose(output_valid[0]) |-> $past(blank_settled[0]) || $past(blank_settled[0], 2);
  endproperty
  property p_ev_a_clear;
    $fell(power_alarm_event[0]) |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3);
  endproperty
  property p_ev_b_clear;
    $fell(power_alarm_event[1]) |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved");
  a_rotation_blanks: assert property (p_rotation_blanks) else $error("no blank");
  a_blank_pulse: assert property (p_blank_pulse) else $error("blank pulse long");
  a_pd_a: assert property (p_pd_a) else $error("pair a powerdown w/o fall");
  a_pd_b: assert property (p_pd_b) else $error("pair b powerdown w/o fall");
  a_valid_settled: assert property (p_valid_settled) else $error("valid early");
  a_ev_a_clear: assert property (p_ev_a_clear) else $error("event a lost");
  a_ev_b_clear: assert property (p_ev_b_clear) else $error("event b lost");
  c_valid: cover property ($rose(output_valid[0]));
  c_powerdown: cover property ($rose(pair_powerdown[0]));
  c_event: cover property ($rose(power_alarm_event[0]));
endmodule

bind downstream_power_protection downstream_power_protection_props u_props (
  .clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .transmit_enable_pin(transmit_enable_pin), .sync_rotation(sync_rotation),
  .blank_settled(blank_settled), .blanking_start(blanking_start),
  .pair_powerdown(pair_powerdown), .output_valid(output_valid),
  .power_alarm_event(power_alarm_event)
);

/* File: dv/sample_source.sv */
// partner model: sample streams and blanking-settle responder for both pairs
`timescale 1ns/1ps
module sample_source
(
  input  wire logic        clk,
  input  wire logic [1:0]  loud,
  input  wire logic [1:0]  blanking_start,
  output logic [15:0]      sample_i_a,
  output logic [15:0]      sample_q_a,
  output logic [15:0]      sample_i_b,
  output logic [15:0]      sample_q_b,
  output logic [1:0]       blank_settled
);
  logic [9:0] ctr = 10'h000;
  logic [3:0] cnt [2] = '{4'hF, 4'hF};
  // quiet data keeps the top bits clear but toggles every cycle
  assign sample_i_a = loud[0] ? 16'h7FFF : {6'h00, ctr};
  assign sample_q_a = loud[0] ? 16'h7FFF : {6'h00, ~ctr};
  assign sample_i_b = loud[1] ? 16'h7FFF : {6'h00, ctr};
  assign sample_q_b = loud[1] ? 16'h7FFF : {6'h00, ~ctr};
  // gain stays enabled here, so each ramp settles after a fixed time
  assign blank_settled = {cnt[1] >= 4'h8, cnt[0] >= 4'h8};
  always @(posedge clk)
  begin
    ctr <= ctr + 10'h001;
    for (int k = 0; k < 2; k++)
      if (blanking_start[k])
        cnt[k] <= 4'h0;
      else if (cnt[k] != 4'hF)
        cnt[k] <= cnt[k] + 4'h1;
  end
endmodule

/* File: dv/tb_downstream_power_protection.sv */
// testbench: register-driven checks of detector, sequencer and protect output
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_downstream_power_protection;
  import guard_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00;
  logic [1:0]  te_pin = 2'b00;
  logic [1:0]  sync_rot = 2'b00;
  logic [1:0]  loud = 2'b00;
  logic [7:0]  reg_rdata, rv;
  logic [1:0]  settled, guard_out, blank_go, pdown, valid, alarm_ev;
  logic [15:0] si_a, sq_a, si_b, sq_b;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          t;
  always #50 clk = ~clk;
  downstream_power_protection DUT (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .transmit_enable_pin(te_pin), .sync_rotation(sync_rot), .blank_settled(settled),
    .sample_i_a(si_a), .sample_q_a(sq_a), .sample_i_b(si_b), .sample_q_b(sq_b),
    .downstream_guard_out(guard_out), .blanking_start(blank_go), .pair_powerdown(pdown),
    .output_valid(valid), .power_alarm_event(alarm_ev));
  sample_source u_src (.clk(clk), .loud(loud), .blanking_start(blank_go), .sample_i_a(si_a),
    .sample_q_a(sq_a), .sample_i_b(si_b), .sample_q_b(sq_b), .blank_settled(settled));
  // -------------------------------------------------------------------
  // access tasks
  // -------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    reg_rd = 1'b1;
    reg_addr = a;
    cyc(1);
    reg_rd = 1'b0;
    d = reg_rdata;
    cyc(1);
  endtask
  task automatic wait_pulse(input int lim);
    t = 0;
    while (blank_go[0] !== 1'b1 && t < lim)
    begin
      cyc(1);
      t++;
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // -------------------------------------------------------------------
  // tests
  // -------------------------------------------------------------------
  initial
  begin
    cyc(6);
    nrst = 1'b1;
    cyc(3);
    rd(GUARD_COUNTER_SELECT_ADDR, rv);
    `CHK("counter_select", COUNTER_SEL_RESET, rv)
    rd(FALL_DELAY_FIRST_ADDR, rv);
    `CHK("fall_first", FALL_FIRST_RESET, rv)
    rd(12'h7FF, rv);
    `CHK("unmapped", 8'h00, rv)
    wr(PAGE_SELECT_ADDR, 8'h01);
    wr(GUARD_COUNTER_SELECT_ADDR, 8'h60);
    wr(RISE_DELAY_FIRST_ADDR, 8'h01);
    wr(RISE_DELAY_SECOND_ADDR, 8'h02);
    wr(FALL_DELAY_FIRST_ADDR, 8'h12);
    wr(POWERDOWN_MASK_ADDR, 8'h01);
    te_pin = 2'b11;
    wait_pulse(200);
    `CHK("rise_delay", 1'b1, t >= 96 && t <= 104)
    cyc(1);
    `CHK("valid_wait", 1'b0, valid[0])
    cyc(1);
    te_pin = 2'b00;
    wait_pulse(700);
    `CHK("fall_delay", 1'b1, t >= 576 && t <= 584)
    `CHK("powerdown", 2'b01, pdown)
    te_pin = 2'b01;
    cyc(300);
    `CHK("valid_early", 1'b0, valid[0])
    t = 0;
    while (valid[0] !== 1'b1 && t < 400)
    begin
      cyc(1);
      t++;
    end
    `CHK("valid_late", 1'b1, valid[0])
    wr(POWER_LIMIT_LOW_ADDR, 8'hE8);
    wr(POWER_LIMIT_HIGH_ADDR, 8'h03);
    rd(POWER_LIMIT_HIGH_ADDR, rv);
    `CHK("limit_high", 8'h03, rv)
    wr(IRQ_ENABLE_A_ADDR, 8'h80);
    wr(POWER_MONITOR_CONTROL_ADDR, 8'h80);
    loud = 2'b01;
    cyc(1300);
    rd(POWER_READBACK_LOW_ADDR, rv);
    `CHK("readback_low", 8'h82, rv)
    rd(POWER_READBACK_HIGH_ADDR, rv);
    `CHK("readback_high", 8'h07, rv)
    `CHK("alarm_event", 2'b01, alarm_ev)
    rd(IRQ_STATUS_A_ADDR, rv);
    `CHK("status_a", 1'b1, rv[7])
    wr(IRQ_STATUS_A_ADDR, 8'h80);
    cyc(3);
    `CHK("status_cleared", 1'b0, alarm_ev[0])
    wr(PROTECT_SOURCE_ADDR, 8'h00);
    `CHK("protect_idle", 1'b1, guard_out[0])
    wr(PROTECT_SOURCE_ADDR, 8'h0C);
    cyc(2);
    `CHK("soft_protect", 1'b0, guard_out[0])
    wr(GUARD_COUNTER_SELECT_ADDR, 8'h64);
    wr(PROTECT_SOURCE_ADDR, 8'h40);
    cyc(2);
    `CHK("alarm_protect", 1'b1, guard_out[0])
    wr(PROTECT_SOURCE_ADDR, 8'h00);
    cyc(2);
    `CHK("inverted_idle", 1'b0, guard_out[0])
    sync_rot = 2'b10;
    cyc(1);
    `CHK("rotation_blank", 1'b1, blank_go[1])
    sync_rot = 2'b00;
    cyc(4);
    print_verdict();
  end
  // whole sequence needs about 2400 cycles; allow roughly four times that
  initial
  begin
    #(10000 * 100);
    n_mismatch++;
    print_verdict();
  end
endmodule

/* File: rtl/downstream_power_protection.sv */
// downstream protection: power detectors, transmit-enable sequencers, protect outputs
`timescale 1ns/1ps
module downstream_power_protection
  import guard_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic [7:0]       reg_rdata,
  input  wire logic [1:0]  transmit_enable_pin,
  input  wire logic [1:0]  sync_rotation,
  input  wire logic [1:0]  blank_settled,
  input  wire logic [15:0] sample_i_a,
  input  wire logic [15:0] sample_q_a,
  input  wire logic [15:0] sample_i_b,
  input  wire logic [15:0] sample_q_b,
  output logic [1:0]       downstream_guard_out,
  output logic [1:0]       blanking_start,
  output logic [1:0]       pair_powerdown,
  output logic [1:0]       output_valid,
  output logic [1:0]       power_alarm_event
);
  import guard_pkg::*;

  // ------------------------------------------------------------
  // registers, one copy per pair except page select, powerdown mask and read data
  // ------------------------------------------------------------
  logic [7:0]  page_ff, nxt_page, mask_ff, nxt_mask, rdata_ff, nxt_rdata;
  logic [7:0]  lim_lo_ff [2], lim_hi_ff [2], mon_ff [2], src_ff [2], sel_ff [2];
  logic [7:0]  r0_ff [2], r1_ff [2], f0_ff [2], f1_ff [2], irq_en_ff [2];
  logic [7:0]  nxt_lim_lo [2], nxt_lim_hi [2], nxt_mon [2], nxt_src [2], nxt_sel [2];
  logic [7:0]  nxt_r0 [2], nxt_r1 [2], nxt_f0 [2], nxt_f1 [2], nxt_irq_en [2];
  logic [1:0]  stat_ff, nxt_stat;
  logic [12:0] readback [2];
  logic [1:0]  alarm, alarm_d_ff;
  logic [1:0]  sel_p;
  logic        rd_p;

  // ------------------------------------------------------------
  // detectors
  // ------------------------------------------------------------
  power_average u_det_a (
    .clk(clk), .nrst(nrst), .enable(mon_ff[0][POWER_MONITOR_ON_BIT]), .window(mon_ff[0][3:0]),
    .limit({lim_hi_ff[0][4:0], lim_lo_ff[0]}), .sample_i(sample_i_a), .sample_q(sample_q_a),
    .alarm(alarm[0]), .readback(readback[0]));
  power_average u_det_b (
    .clk(clk), .nrst(nrst), .enable(mon_ff[1][POWER_MONITOR_ON_BIT]), .window(mon_ff[1][3:0]),
    .limit({lim_hi_ff[1][4:0], lim_lo_ff[1]}), .sample_i(sample_i_b), .sample_q(sample_q_b),
    .alarm(alarm[1]), .readback(readback[1]));

  always_comb
  begin
    sel_p = page_ff[1:0];
    rd_p  = page_ff[1] & ~page_ff[0];
    nxt_page  = page_ff;
    nxt_mask  = mask_ff;
    nxt_rdata = rdata_ff;
    nxt_stat  = stat_ff;
    for (int p = 0; p < 2; p++)
    begin
      nxt_lim_lo[p] = lim_lo_ff[p]; nxt_lim_hi[p] = lim_hi_ff[p]; nxt_mon[p] = mon_ff[p];
      nxt_src[p] = src_ff[p]; nxt_sel[p] = sel_ff[p]; nxt_r0[p] = r0_ff[p];
      nxt_r1[p] = r1_ff[p]; nxt_f0[p] = f0_ff[p]; nxt_f1[p] = f1_ff[p];
      nxt_irq_en[p] = irq_en_ff[p];
    end
    if (reg_wr)
    begin
      if (reg_addr == PAGE_SELECT_ADDR)
        nxt_page = reg_wdata;
      else if (reg_addr == POWERDOWN_MASK_ADDR)
        nxt_mask = {6'h00, reg_wdata[1:0]};
      else if (reg_addr == IRQ_ENABLE_A_ADDR)
        nxt_irq_en[0] = reg_wdata;
      else if (reg_addr == IRQ_ENABLE_B_ADDR)
        nxt_irq_en[1] = reg_wdata;
      else
        for (int p = 0; p < 2; p++)
          if (sel_p[p])
          begin
            if (reg_addr == POWER_LIMIT_LOW_ADDR) nxt_lim_lo[p] = reg_wdata;
            else if (reg_addr == POWER_LIMIT_HIGH_ADDR) nxt_lim_hi[p] = {3'h0, reg_wdata[4:0]};
            else if (reg_addr == POWER_MONITOR_CONTROL_ADDR) nxt_mon[p] = reg_wdata & 8'h8F;
            else if (reg_addr == PROTECT_SOURCE_ADDR) nxt_src[p] = reg_wdata & 8'h6C;
            else if (reg_addr == GUARD_COUNTER_SELECT_ADDR) nxt_sel[p] = reg_wdata & 8'hF4;
            else if (reg_addr == RISE_DELAY_FIRST_ADDR) nxt_r0[p] = reg_wdata;
            else if (reg_addr == RISE_DELAY_SECOND_ADDR) nxt_r1[p] = reg_wdata;
            else if (reg_addr == FALL_DELAY_FIRST_ADDR) nxt_f0[p] = reg_wdata;
            else if (reg_addr == FALL_DELAY_SECOND_ADDR) nxt_f1[p] = reg_wdata;
          end
    end
    // write one to clear; a new event in the same cycle wins
    if (reg_wr && reg_addr == IRQ_STATUS_A_ADDR && reg_wdata[POWER_ALARM_IRQ_BIT])
      nxt_stat[0] = 1'b0;
    if (reg_wr && reg_addr == IRQ_STATUS_B_ADDR && reg_wdata[POWER_ALARM_IRQ_BIT])
      nxt_stat[1] = 1'b0;
    for (int p = 0; p < 2; p++)
      if (alarm[p] && !alarm_d_ff[p] && irq_en_ff[p][POWER_ALARM_IRQ_BIT])
        nxt_stat[p] = 1'b1;
    if (reg_rd)
    begin
      if (reg_addr == PAGE_SELECT_ADDR) nxt_rdata = page_ff;
      else if (reg_addr == POWERDOWN_MASK_ADDR) nxt_rdata = mask_ff;
      else if (reg_addr == IRQ_ENABLE_A_ADDR) nxt_rdata = irq_en_ff[0];
      else if (reg_addr == IRQ_ENABLE_B_ADDR) nxt_rdata = irq_en_ff[1];
      else if (reg_addr == IRQ_STATUS_A_ADDR) nxt_rdata = {stat_ff[0], 7'h00};
      else if (reg_addr == IRQ_STATUS_B_ADDR) nxt_rdata = {stat_ff[1], 7'h00};
      else if (reg_addr == POWER_LIMIT_LOW_ADDR) nxt_rdata = lim_lo_ff[rd_p];
      else if (reg_addr == POWER_LIMIT_HIGH_ADDR) nxt_rdata = lim_hi_ff[rd_p];
      else if (reg_addr == POWER_MONITOR_CONTROL_ADDR) nxt_rdata = mon_ff[rd_p];
      else if (reg_addr == POWER_READBACK_LOW_ADDR) nxt_rdata = readback[rd_p][7:0];
      else if (reg_addr == POWER_READBACK_HIGH_ADDR) nxt_rdata = {3'h0, readback[rd_p][12:8]};
      else if (reg_addr == PROTECT_SOURCE_ADDR) nxt_rdata = src_ff[rd_p];
      else if (reg_addr == GUARD_COUNTER_SELECT_ADDR) nxt_rdata = sel_ff[rd_p];
      else if (reg_addr == RISE_DELAY_FIRST_ADDR) nxt_rdata = r0_ff[rd_p];
      else if (reg_addr == RISE_DELAY_SECOND_ADDR) nxt_rdata = r1_ff[rd_p];
      else if (reg_addr == FALL_DELAY_FIRST_ADDR) nxt_rdata = f0_ff[rd_p];
      else if (reg_addr == FALL_DELAY_SECOND_ADDR) nxt_rdata = f1_ff[rd_p];
      else nxt_rdata = ZERO8;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      page_ff <= PAGE_RESET; mask_ff <= ZERO8; rdata_ff <= ZERO8; stat_ff <= 2'b00;
      alarm_d_ff <= 2'b00;
      for (int p = 0; p < 2; p++)
      begin
        lim_lo_ff[p] <= ZERO8; lim_hi_ff[p] <= ZERO8; mon_ff[p] <= ZERO8; src_ff[p] <= ZERO8;
        sel_ff[p] <= COUNTER_SEL_RESET; r0_ff[p] <= ZERO8; r1_ff[p] <= ZERO8;
        f0_ff[p] <= FALL_FIRST_RESET; f1_ff[p] <= ZERO8; irq_en_ff[p] <= ZERO8;
      end
    end
    else
    begin
      page_ff <= nxt_page; mask_ff <= nxt_mask; rdata_ff <= nxt_rdata; stat_ff <= nxt_stat;
      alarm_d_ff <= alarm;
      for (int p = 0; p < 2; p++)
      begin
        lim_lo_ff[p] <= nxt_lim_lo[p]; lim_hi_ff[p] <= nxt_lim_hi[p]; mon_ff[p] <= nxt_mon[p];
        src_ff[p] <= nxt_src[p]; sel_ff[p] <= nxt_sel[p]; r0_ff[p] <= nxt_r0[p];
        r1_ff[p] <= nxt_r1[p]; f0_ff[p] <= nxt_f0[p]; f1_ff[p] <= nxt_f1[p];
        irq_en_ff[p] <= nxt_irq_en[p];
      end
    end
  end

  // ------------------------------------------------------------
  // transmit-enable sequencers and protect outputs
  // ------------------------------------------------------------
  logic [1:0]  transmit_enable_pin_s1_ff, transmit_enable_pin_s2_ff, transmit_enable_pin_s3_ff;
  seq_state_t  st_ff [2], nxt_st [2];
  logic [13:0] dly_ff [2], nxt_dly [2];
  logic [12:0] pon_ff [2], nxt_pon [2];
  logic [1:0]  guard_ff, nxt_guard, pd_ff, nxt_pd, prot_ff, nxt_prot, valid_ff, nxt_valid;
  logic [1:0]  blank_ff, nxt_blank, evt_ff, nxt_evt;
  logic [1:0]  rise, fall;

  // delay in cycles of one counter value
  function automatic logic [13:0] span(input logic [7:0] v);
    span = 14'(v) * 14'(TICKS_PER_UNIT);
  endfunction

  always_comb
  begin
    rise = transmit_enable_pin_s2_ff & ~transmit_enable_pin_s3_ff;
    fall = ~transmit_enable_pin_s2_ff & transmit_enable_pin_s3_ff;
    nxt_guard = guard_ff; nxt_pd = pd_ff; nxt_prot = prot_ff; nxt_valid = valid_ff;
    nxt_blank = blank_ff; nxt_evt = stat_ff;
    for (int p = 0; p < 2; p++)
    begin
      nxt_st[p]  = st_ff[p];
      nxt_dly[p] = (dly_ff[p] != 14'h0) ? dly_ff[p] - 14'h1 : 14'h0;
      nxt_pon[p] = (pon_ff[p] != 13'h0) ? pon_ff[p] - 13'h1 : 13'h0;
      if (fall[p])
      begin
        nxt_st[p]  = SEQ_FALL;
        nxt_dly[p] = span(f0_ff[p]) + ((sel_ff[p][7:6] == 2'd2) ? span(f1_ff[p]) : 14'h0);
        nxt_pd[p]  = mask_ff[p];
      end
      else if (rise[p])
      begin
        nxt_pd[p] = 1'b0;
        if (pd_ff[p])
          nxt_pon[p] = 13'(POWER_ON_CYC);
        if (sel_ff[p][5:4] == 2'd0)
          nxt_st[p] = SEQ_ON;
        else
        begin
          nxt_st[p]  = SEQ_RISE1;
          nxt_dly[p] = span(r0_ff[p]);
        end
      end
      else
        case (st_ff[p])
          SEQ_RISE1:
            if (dly_ff[p] == 14'h0)
            begin
              if (sel_ff[p][5:4] >= 2'd2)
              begin
                nxt_st[p]  = SEQ_RISE2;
                nxt_dly[p] = span(r1_ff[p]);
              end
              else
                nxt_st[p] = SEQ_ON;
            end
          SEQ_RISE2: if (dly_ff[p] == 14'h0) nxt_st[p] = SEQ_ON;
          SEQ_FALL:  if (dly_ff[p] == 14'h0) nxt_st[p] = SEQ_OFF;
          SEQ_ON:    nxt_st[p] = SEQ_ON;
          default:   nxt_st[p] = SEQ_OFF;
        endcase
      nxt_guard[p] = (nxt_st[p] == SEQ_ON) || (nxt_st[p] == SEQ_FALL);
      // guard edges and sync rotation both kick the blanking ramp
      nxt_blank[p] = (nxt_guard[p] != guard_ff[p]) | sync_rotation[p];
      // settled still shows the old ramp while a fresh blanking pulse is out
      nxt_valid[p] = guard_ff[p] & blank_settled[p] & (pon_ff[p] == 13'h0)
                     & ~pd_ff[p] & ~blank_ff[p];
      // protect is asserted on alarm, on guard low, on software flag (each only when its source bit is set), or while blank_settled is low
      nxt_prot[p] = ((src_ff[p][SRC_ALARM_BIT] & alarm[p])
                    | (src_ff[p][SRC_GUARD_BIT] & ~guard_ff[p])
                    | (src_ff[p][SRC_SOFT_EN_BIT] & src_ff[p][SRC_SOFT_SET_BIT])
                    | ~blank_settled[p]) ^ ~sel_ff[p][PROTECT_INVERT_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      transmit_enable_pin_s1_ff <= 2'b00; transmit_enable_pin_s2_ff <= 2'b00; transmit_enable_pin_s3_ff <= 2'b00;
      guard_ff <= 2'b00; pd_ff <= 2'b00; prot_ff <= 2'b00; valid_ff <= 2'b00;
      blank_ff <= 2'b00; evt_ff <= 2'b00;
      for (int p = 0; p < 2; p++)
      begin
        st_ff[p] <= SEQ_OFF; dly_ff[p] <= 14'h0; pon_ff[p] <= 13'h0;
      end
    end
    else
    begin
      transmit_enable_pin_s1_ff <= transmit_enable_pin; transmit_enable_pin_s2_ff <= transmit_enable_pin_s1_ff; transmit_enable_pin_s3_ff <= transmit_enable_pin_s2_ff;
      guard_ff <= nxt_guard; pd_ff <= nxt_pd; prot_ff <= nxt_prot; valid_ff <= nxt_valid;
      blank_ff <= nxt_blank; evt_ff <= nxt_evt;
      for (int p = 0; p < 2; p++)
      begin
        st_ff[p] <= nxt_st[p]; dly_ff[p] <= nxt_dly[p]; pon_ff[p] <= nxt_pon[p];
      end
    end
  end

  assign reg_rdata            = rdata_ff;
  assign downstream_guard_out = prot_ff;
  assign blanking_start       = blank_ff;
  assign pair_powerdown       = pd_ff;
  assign output_valid         = valid_ff;
  assign power_alarm_event    = evt_ff;
endmodule

/* File: rtl/guard_pkg.sv */
// package: register map, field positions, reset values and timing of the protection block
package guard_pkg;
  localparam logic [11:0] POWER_LIMIT_LOW_ADDR       = 12'h060;
  localparam logic [11:0] POWER_LIMIT_HIGH_ADDR      = 12'h061;
  localparam logic [11:0] POWER_MONITOR_CONTROL_ADDR = 12'h062;
  localparam logic [11:0] POWER_READBACK_LOW_ADDR    = 12'h063;
  localparam logic [11:0] POWER_READBACK_HIGH_ADDR   = 12'h064;
  localparam logic [11:0] PAGE_SELECT_ADDR           = 12'h008;
  localparam logic [11:0] POWERDOWN_MASK_ADDR        = 12'h012;
  localparam logic [11:0] PROTECT_SOURCE_ADDR        = 12'h013;
  localparam logic [11:0] IRQ_ENABLE_A_ADDR          = 12'h021;
  localparam logic [11:0] IRQ_ENABLE_B_ADDR          = 12'h022;
  localparam logic [11:0] IRQ_STATUS_A_ADDR          = 12'h025;
  localparam logic [11:0] IRQ_STATUS_B_ADDR          = 12'h026;
  localparam logic [11:0] GUARD_COUNTER_SELECT_ADDR  = 12'h11F;
  localparam logic [11:0] RISE_DELAY_FIRST_ADDR      = 12'h121;
  localparam logic [11:0] RISE_DELAY_SECOND_ADDR     = 12'h122;
  localparam logic [11:0] FALL_DELAY_FIRST_ADDR      = 12'h123;
  localparam logic [11:0] FALL_DELAY_SECOND_ADDR     = 12'h124;

  localparam int POWER_MONITOR_ON_BIT   = 7;
  localparam int POWER_ALARM_IRQ_BIT    = 7;
  localparam int SRC_ALARM_BIT          = 6;
  localparam int SRC_GUARD_BIT          = 5;
  localparam int SRC_SOFT_EN_BIT        = 3;
  localparam int SRC_SOFT_SET_BIT       = 2;
  localparam int PROTECT_INVERT_BIT     = 2;
  localparam int FALL_SEL_LSB           = 6;
  localparam int RISE_SEL_LSB           = 4;
  localparam int SAMPLE_MSBS            = 6;
  localparam int WINDOW_BASE_LOG2       = 9;
  localparam logic [3:0] WINDOW_MAX     = 4'hA;
  localparam int ACC_W                  = 32;

  localparam logic [7:0] PAGE_RESET        = 8'h03;
  localparam logic [7:0] COUNTER_SEL_RESET = 8'h40;
  localparam logic [7:0] FALL_FIRST_RESET  = 8'h12;
  localparam logic [7:0] ZERO8             = 8'h00;
  localparam logic [5:0] TICKS_PER_UNIT    = 6'h20;

  localparam int CLK_NS        = 100;
  localparam int POWER_ON_US   = 35;
  localparam int POWER_ON_CYC  = (POWER_ON_US * 1000 + CLK_NS - 1) / CLK_NS;

  typedef enum logic [4:0] {
    SEQ_OFF   = 5'b00001,
    SEQ_RISE1 = 5'b00010,
    SEQ_RISE2 = 5'b00100,
    SEQ_ON    = 5'b01000,
    SEQ_FALL  = 5'b10000
  } seq_state_t;
endpackage

/* File: rtl/power_average.sv */
// one pair's block-average power detector
`timescale 1ns/1ps
module power_average
  import guard_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        enable,
  input  wire logic [3:0]  window,
  input  wire logic [12:0] limit,
  input  wire logic [15:0] sample_i,
  input  wire logic [15:0] sample_q,
  output logic             alarm,
  output logic [12:0]      readback
);
  // the average is kept as an exponential-free running window: a block sum over 2^(9+N)
  // samples, refreshed each window; this keeps storage to flip-flops only
  logic [ACC_W-1:0] acc_ff, nxt_acc;
  logic [19:0]      cnt_ff, nxt_cnt;
  logic [12:0]      avg_ff, nxt_avg, inst_ff, nxt_inst, peak_ff, nxt_peak;
  logic             alarm_ff, nxt_alarm, crossed_ff, nxt_crossed;
  logic [3:0]       win;
  logic [11:0]      pwr;
  logic [5:0]       mi, mq;
  logic [19:0]      last;

  always_comb
  begin
    win   = (window > WINDOW_MAX) ? WINDOW_MAX : window;
    mi    = sample_i[15:10];
    mq    = sample_q[15:10];
    pwr   = 12'(($signed(mi) * $signed(mi)) + ($signed(mq) * $signed(mq)));
    last  = 20'((32'h1 << (WINDOW_BASE_LOG2 + 32'(win))) - 32'h1);
    nxt_acc     = acc_ff;
    nxt_cnt     = cnt_ff;
    nxt_avg     = avg_ff;
    nxt_inst    = 13'(pwr);
    nxt_peak    = peak_ff;
    nxt_alarm   = alarm_ff;
    nxt_crossed = crossed_ff;
    if (!enable)
    begin
      nxt_acc = '0;
      nxt_cnt = '0;
      nxt_alarm = 1'b0;
    end
    else
    begin
      nxt_acc = acc_ff + ACC_W'(pwr);
      nxt_cnt = cnt_ff + 20'h1;
      if (cnt_ff >= last)
      begin
        nxt_avg = 13'((acc_ff + ACC_W'(pwr)) >> (WINDOW_BASE_LOG2 + 32'(win)));
        nxt_acc = '0;
        nxt_cnt = '0;
      end
      nxt_alarm = (avg_ff > limit);
      if (avg_ff > limit)
      begin
        nxt_crossed = 1'b1;
        if (avg_ff > peak_ff)
          nxt_peak = avg_ff;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      acc_ff <= '0; cnt_ff <= '0; avg_ff <= '0; inst_ff <= '0;
      peak_ff <= '0; alarm_ff <= 1'b0; crossed_ff <= 1'b0;
    end
    else
    begin
      acc_ff <= nxt_acc; cnt_ff <= nxt_cnt; avg_ff <= nxt_avg; inst_ff <= nxt_inst;
      peak_ff <= nxt_peak; alarm_ff <= nxt_alarm; crossed_ff <= nxt_crossed;
    end
  end

  assign alarm    = alarm_ff;
  assign readback = crossed_ff ? peak_ff : inst_ff;
endmodule
